// ---- adsc_pkg.sv ----
// Purpose: Shared constants for the audio DSP serial command interpreter
// Assumes: Host software tokenises each text command into the APB command registers
// Notes: Rules carried by the command set follow
// Function
// - A command carries unit address 0 to 7, or the asterisk selecting every unit.
// - Stage setup needs node 1-4 on mic, 1-15 on processing; else reject.
// - Stage type 0..11: none, all-pass, LP, HP, shelves, PEQ, horn, crossovers, notch.
// - Frequency 0 for type 0, 500-5000 for type 7, else 20-20000.
// - Gain +-15.00 types 4-6; slopes per crossover; notch -80; else 0.
// - Bandwidth .05-5.00 for PEQ and notch; crossover section 2 low, 3 high.
// - A command without its setting argument is a query returning the stored value.
// - On/off values: 0 off, 1 on, 2 inverts the stored state.
// - With hardware handshake on, transfers are paced by DTR and DSR.
// - First talker priority held per gating group, addressed 1-4 or A-D.
// - Passcode is five symbols 1-5: up, enter, escape, down, meter.
// - Panel unlocks only when button presses match the passcode in order; the code also unlocks while the stored passcode is zero.
// - CLEAR erases the passcode; no argument reports it.
// - Level entries -99 to 99 on I, O, M, P, L groups; omission queries.
// - Stored level is clamped to -65 through 20.
// - Requested level below -65 mutes the channel.
// - Suffix A is absolute, R or none is relative.
// - Gate status takes no setting argument; it only reports.
// - Gate reply is two hex digits, high first; bit n is mic n+1 gated on.
// - Gate hold time 0.10 to 8.00 s per mic; omission reports it.
package adsc_pkg;
   // Register byte offsets
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_ARG0 = 8'h04;
   localparam logic [7:0] A_ARG1 = 8'h08;
   localparam logic [7:0] A_ARG2 = 8'h0C;
   localparam logic [7:0] A_ARG3 = 8'h10;
   localparam logic [7:0] A_STATUS = 8'h14;
   localparam logic [7:0] A_REPLY0 = 8'h18;
   localparam logic [7:0] A_REPLY1 = 8'h1C;
   localparam logic [7:0] A_UNIT = 8'h20;
   localparam logic [7:0] A_GATE = 8'h24;
   // Command word fields
   localparam int C_OP = 0;
   localparam int C_UNIT = 4;
   localparam int C_ALL = 7;
   localparam int C_QRY = 8;
   localparam int C_CH = 9;
   localparam int C_GRP = 13;
   localparam int C_NODE = 16;
   localparam int C_NALL = 20;
   localparam int C_CLR = 21;
   localparam int C_ABS = 22;
   typedef enum logic [3:0] {
      OP_EQ = 4'h0, OP_SW = 4'h1, OP_FLOW = 4'h2, OP_FTP = 4'h3,
      OP_PASS = 4'h4, OP_LVL = 4'h5, OP_GATE = 4'h6, OP_HOLD = 4'h7
   } adsc_op_e;
   typedef enum logic [2:0] {
      GRP_I = 3'h0, GRP_O = 3'h1, GRP_M = 3'h2, GRP_P = 3'h3, GRP_L = 3'h4
   } adsc_grp_e;
   // Argument limits
   localparam logic [15:0] FREQ_MIN = 16'h0014;
   localparam logic [15:0] FREQ_MAX = 16'h4E20;
   localparam logic [15:0] HORN_MIN = 16'h01F4;
   localparam logic [15:0] HORN_MAX = 16'h1388;
   localparam logic signed [15:0] SHELF_MAX = 16'sh05DC;
   localparam logic signed [15:0] NOTCH_GAIN = -16'sh0050;
   localparam logic [15:0] BW_MIN = 16'h0005;
   localparam logic [15:0] BW_MAX = 16'h01F4;
   localparam logic signed [15:0] LVL_ENTRY = 16'sh0063;
   localparam logic signed [8:0] LVL_MIN = -9'sh041;
   localparam logic signed [8:0] LVL_MAX = 9'sh014;
   localparam logic [15:0] HOLD_MIN = 16'h000A;
   localparam logic [15:0] HOLD_MAX = 16'h0320;
   // Values after reset
   localparam logic [15:0] HOLD_RST = 16'h0064;
   localparam logic [2:0] UNIT_RST = 3'h0;
   localparam logic [7:0] LVL_RST = 8'h00;
endpackage

// ---- adsc_top.sv ----
// Purpose: Executes tokenised set/query commands and holds the mixer settings
// Assumes: APB master on ref_clk_in; gate, button and DSR pins are asynchronous
// Notes: Writing CMD starts one execute cycle; results land in STATUS and REPLY
module adsc_top #(
   parameter int MIC_NUM = 8
) (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [MIC_NUM-1:0] gate_in,
   input wire logic [4:0] btn_in,
   input wire logic dsr_in,
   input wire logic rx_ready_in,
   output logic dtr_out,
   output logic tx_allow_out,
   output logic panel_unlocked_out,
   output logic unlock_pulse_out
);
   import adsc_pkg::*;

   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} adsc_st_e;

   adsc_st_e st_q, st_d;
   logic [31:0] cmd_q, cmd_d, arg0_q, arg0_d, arg1_q, arg1_d, arg2_q, arg2_d, arg3_q, arg3_d;
   logic [31:0] reply0_q, reply0_d, reply1_q, reply1_d;
   logic err_q, err_d, skip_q, skip_d, flow_q, flow_d;
   logic [2:0] unit_q, unit_d;
   logic [3:0] ftp_q, ftp_d;
   logic [14:0] pass_q, pass_d;
   logic [255:0] sw_q, sw_d;
   logic [7:0] lvl_q [0:127];
   logic [7:0] lvl_d [0:127];
   logic [127:0] mute_q, mute_d;
   logic [15:0] hold_q [0:7];
   logic [15:0] hold_d [0:7];
   logic [51:0] eq_mem [0:255];
   logic eq_we;
   logic [51:0] eq_wdata;
   logic [MIC_NUM-1:0] gate_m, gate_s;
   logic [4:0] btn_m, btn_s, btn_l, btn_p;
   logic dsr_m, dsr_s;
   logic [2:0] pidx_q, pidx_d;
   logic unl_q, unl_d, upls_q, upls_d;

   // Command fields
   logic [3:0] op, ch, node, typ;
   logic [2:0] grp, ch0;
   logic qry, nall, clr, sabs, hit;
   assign op = cmd_q[C_OP +: 4];
   assign hit = cmd_q[C_ALL] || (cmd_q[C_UNIT +: 3] == unit_q);
   assign qry = cmd_q[C_QRY];
   assign ch = cmd_q[C_CH +: 4];
   assign ch0 = 3'(ch - 4'h1);
   assign grp = cmd_q[C_GRP +: 3];
   assign node = cmd_q[C_NODE +: 4];
   assign nall = cmd_q[C_NALL];
   assign clr = cmd_q[C_CLR];
   assign sabs = cmd_q[C_ABS];
   assign typ = arg0_q[3:0];
   // Gating group 1-4 or A-D to index 0-3
   logic [1:0] ftp_idx;
   assign ftp_idx = 2'(ch[1:0] - (ch[3] ? 2'h2 : 2'h1));

   // Stage argument checks
   logic ch8_ok, node_ok, typ_ok, freq_ok, gain_ok, bw_ok, eq_ok;
   logic [15:0] freq, bw;
   logic signed [15:0] gain, gain_st;
   logic [7:0] eq_idx;
   assign freq = arg1_q[15:0];
   assign gain = arg2_q[15:0];
   assign bw = arg3_q[15:0];
   assign ch8_ok = (ch >= 4'h1) && (ch <= 4'h8);
   assign node_ok = (grp == GRP_M) ? (node >= 4'h1 && node <= 4'h4) :
                    (grp == GRP_P) ? (node >= 4'h1) : 1'b0;
   assign typ_ok = arg0_q[15:0] <= 16'h000B;
   assign freq_ok = (typ == 4'h0) ? (freq == 16'h0000) :
                    (typ == 4'h7) ? (freq >= HORN_MIN && freq <= HORN_MAX) :
                    (freq >= FREQ_MIN && freq <= FREQ_MAX);
   always_comb begin
      gain_ok = 1'b1;
      gain_st = 16'sh0000;
      case (typ)
         4'h4, 4'h5, 4'h6: begin
            gain_ok = (gain >= -SHELF_MAX) && (gain <= SHELF_MAX);
            gain_st = gain;
         end
         4'h8, 4'h9: begin
            gain_ok = gain == 16'sh000C || gain == 16'sh0012 || gain == 16'sh0018;
            gain_st = gain;
         end
         4'hA: begin
            gain_ok = gain == 16'sh000C || gain == 16'sh0018;
            gain_st = gain;
         end
         4'hB: gain_st = NOTCH_GAIN;
         default: gain_st = 16'sh0000;
      endcase
   end
   assign bw_ok = (typ == 4'h6 || typ == 4'hB) ? (bw >= BW_MIN && bw <= BW_MAX) :
                  (typ >= 4'h8 && typ <= 4'hA) ? (bw == 16'h0002 || bw == 16'h0003) :
                  1'b1;
   assign eq_ok = ch8_ok && node_ok && typ_ok && freq_ok && gain_ok && bw_ok;
   assign eq_idx = {grp == GRP_P, ch0, node};

   // Level arithmetic
   logic [6:0] lv_idx;
   logic lv_ok;
   logic signed [8:0] lv_req;
   logic signed [15:0] lv_arg;
   assign lv_idx = {grp, 4'(ch - 4'h1)};
   assign lv_arg = arg0_q[15:0];
   assign lv_ok = grp <= GRP_L && ch >= 4'h1 && ch <= 4'hC &&
                  lv_arg >= -LVL_ENTRY && lv_arg <= LVL_ENTRY;
   assign lv_req = sabs ? lv_arg[8:0] :
                   9'($signed(lvl_q[lv_idx]) + $signed(lv_arg[8:0]));

   // Passcode symbol check
   logic pass_ok;
   always_comb begin
      pass_ok = 1'b1;
      for (int i = 0; i < 5; i++) begin
         if (arg0_q[3*i +: 3] < 3'h1 || arg0_q[3*i +: 3] > 3'h5) begin
            pass_ok = 1'b0;
         end
      end
   end

   function automatic logic [7:0] hex_ch(input logic [3:0] v);
      hex_ch = (v < 4'hA) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
   endfunction

   logic onoff_ok;
   assign onoff_ok = arg0_q[15:0] <= 16'h0002;
   function automatic logic onoff(input logic cur, input logic [1:0] v);
      onoff = (v == 2'h2) ? !cur : v[0];
   endfunction

   // APB slave, zero wait states
   logic apb_acc, wr_acc, mapped;
   assign apb_acc = psel_in && penable_in;
   assign wr_acc = apb_acc && pwrite_in;
   assign mapped = paddr_in[1:0] == 2'h0 && paddr_in <= A_GATE;
   assign pready_out = 1'b1;
   assign pslverr_out = apb_acc && !mapped;
   always_comb begin
      case (paddr_in)
         A_CMD: prdata_out = cmd_q;
         A_ARG0: prdata_out = arg0_q;
         A_ARG1: prdata_out = arg1_q;
         A_ARG2: prdata_out = arg2_q;
         A_ARG3: prdata_out = arg3_q;
         A_STATUS: prdata_out = {28'h000_0000, unl_q, st_q == ST_EXEC, skip_q, err_q};
         A_REPLY0: prdata_out = reply0_q;
         A_REPLY1: prdata_out = reply1_q;
         A_UNIT: prdata_out = {29'h0000_0000, unit_q};
         A_GATE: prdata_out = {{(32-MIC_NUM){1'b0}}, gate_s};
         default: prdata_out = 32'h0000_0000;
      endcase
   end

   // Handshake pacing
   assign tx_allow_out = !flow_q || dsr_s;
   assign dtr_out = !flow_q || rx_ready_in;
   assign panel_unlocked_out = unl_q;
   assign unlock_pulse_out = upls_q;

   // Button code of the lowest pressed button edge
   logic [2:0] bcode;
   // Rising edge taken only behind the second synchroniser flop
   assign btn_p = btn_s & ~btn_l;
   always_comb begin
      bcode = 3'h0;
      for (int i = 4; i >= 0; i--) begin
         if (btn_p[i]) begin
            bcode = 3'(i + 1);
         end
      end
   end

   always_comb begin
      st_d = st_q;
      cmd_d = cmd_q;
      arg0_d = arg0_q;
      arg1_d = arg1_q;
      arg2_d = arg2_q;
      arg3_d = arg3_q;
      reply0_d = reply0_q;
      reply1_d = reply1_q;
      err_d = err_q;
      skip_d = skip_q;
      flow_d = flow_q;
      unit_d = unit_q;
      ftp_d = ftp_q;
      pass_d = pass_q;
      sw_d = sw_q;
      lvl_d = lvl_q;
      mute_d = mute_q;
      hold_d = hold_q;
      eq_we = 1'b0;
      eq_wdata = {bw, gain_st, freq, typ};
      if (wr_acc && paddr_in == A_ARG0) arg0_d = pwdata_in;
      if (wr_acc && paddr_in == A_ARG1) arg1_d = pwdata_in;
      if (wr_acc && paddr_in == A_ARG2) arg2_d = pwdata_in;
      if (wr_acc && paddr_in == A_ARG3) arg3_d = pwdata_in;
      if (wr_acc && paddr_in == A_UNIT) unit_d = pwdata_in[2:0];
      case (st_q)
         ST_IDLE: begin
            if (wr_acc && paddr_in == A_CMD) begin
               cmd_d = pwdata_in;
               st_d = ST_EXEC;
            end
         end
         ST_EXEC: begin
            st_d = ST_IDLE;
            err_d = 1'b0;
            skip_d = !hit;
            if (hit) begin
               case (op)
                  OP_EQ: begin
                     if (!(ch8_ok && node_ok)) begin
                        err_d = 1'b1;
                     end else if (qry) begin
                        reply0_d = {9'h000, eq_mem[eq_idx][19:0], 3'h0};
                        reply1_d = eq_mem[eq_idx][51:20];
                     end else if (eq_ok) begin
                        eq_we = 1'b1;
                     end else begin
                        err_d = 1'b1;
                     end
                  end
                  OP_SW: begin
                     if (!(ch8_ok && (nall ? (grp == GRP_M || grp == GRP_P) : node_ok))) begin
                        err_d = 1'b1;
                     end else if (qry) begin
                        reply0_d = {31'h0000_0000, sw_q[eq_idx]};
                     end else if (!onoff_ok) begin
                        err_d = 1'b1;
                     end else if (nall) begin
                        for (int n = 1; n < 16; n++) begin
                           if (grp == GRP_P || n <= 4) begin
                              sw_d[{grp == GRP_P, ch0, 4'(n)}] =
                                 onoff(sw_q[{grp == GRP_P, ch0, 4'(n)}], arg0_q[1:0]);
                           end
                        end
                     end else begin
                        sw_d[eq_idx] = onoff(sw_q[eq_idx], arg0_q[1:0]);
                     end
                  end
                  OP_FLOW: begin
                     if (qry) reply0_d = {31'h0000_0000, flow_q};
                     else if (onoff_ok) flow_d = onoff(flow_q, arg0_q[1:0]);
                     else err_d = 1'b1;
                  end
                  OP_FTP: begin
                     if (!((ch >= 4'h1 && ch <= 4'h4) || (ch >= 4'hA && ch <= 4'hD))) begin
                        err_d = 1'b1;
                     end else if (qry) begin
                        reply0_d = {31'h0000_0000, ftp_q[ftp_idx]};
                     end else if (onoff_ok) begin
                        ftp_d[ftp_idx] = onoff(ftp_q[ftp_idx], arg0_q[1:0]);
                     end else begin
                        err_d = 1'b1;
                     end
                  end
                  OP_PASS: begin
                     if (clr) pass_d = 15'h0000;
                     else if (qry) reply0_d = {17'h0_0000, pass_q};
                     else if (pass_ok) pass_d = arg0_q[14:0];
                     else err_d = 1'b1;
                  end
                  OP_LVL: begin
                     if (!(grp <= GRP_L && ch >= 4'h1 && ch <= 4'hC)) begin
                        err_d = 1'b1;
                     end else if (qry) begin
                        reply0_d = {23'h00_0000, mute_q[lv_idx], lvl_q[lv_idx]};
                     end else if (!lv_ok) begin
                        err_d = 1'b1;
                     end else if (lv_req < LVL_MIN) begin
                        mute_d[lv_idx] = 1'b1;
                        lvl_d[lv_idx] = LVL_MIN[7:0];
                     end else begin
                        mute_d[lv_idx] = 1'b0;
                        lvl_d[lv_idx] = (lv_req > LVL_MAX) ? LVL_MAX[7:0] : lv_req[7:0];
                     end
                  end
                  OP_GATE: begin
                     if (qry) begin
                        reply0_d = {16'h0000, hex_ch(gate_s[7:4]), hex_ch(gate_s[3:0])};
                     end else begin
                        err_d = 1'b1;
                     end
                  end
                  OP_HOLD: begin
                     if (!ch8_ok) err_d = 1'b1;
                     else if (qry) reply0_d = {16'h0000, hold_q[ch0]};
                     else if (arg0_q[15:0] >= HOLD_MIN && arg0_q[15:0] <= HOLD_MAX)
                        hold_d[ch0] = arg0_q[15:0];
                     else err_d = 1'b1;
                  end
                  default: err_d = 1'b1;
               endcase
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // Panel unlock sequence
   always_comb begin
      pidx_d = pidx_q;
      unl_d = unl_q;
      upls_d = 1'b0;
      if (st_q == ST_EXEC && hit && op == OP_PASS && !qry) begin
         pidx_d = 3'h0;
         unl_d = 1'b0;
      end else if (pass_q == 15'h0000) begin
         unl_d = 1'b1;
      end else if (bcode != 3'h0) begin
         if (bcode == pass_q[14 - 3*pidx_q -: 3]) begin
            pidx_d = (pidx_q == 3'h4) ? 3'h0 : pidx_q + 3'h1;
            if (pidx_q == 3'h4) begin
               unl_d = 1'b1;
               upls_d = 1'b1;
            end
         end else begin
            pidx_d = 3'h0;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      gate_m <= gate_in;
      gate_s <= gate_m;
      btn_m <= btn_in;
      btn_s <= btn_m;
      dsr_m <= dsr_in;
      dsr_s <= dsr_m;
      if (eq_we) eq_mem[eq_idx] <= eq_wdata;
      lvl_q <= lvl_d;
      hold_q <= hold_d;
      if (!nrst_in) begin
         st_q <= ST_IDLE;
         cmd_q <= 32'h0000_0000;
         arg0_q <= 32'h0000_0000;
         arg1_q <= 32'h0000_0000;
         arg2_q <= 32'h0000_0000;
         arg3_q <= 32'h0000_0000;
         reply0_q <= 32'h0000_0000;
         reply1_q <= 32'h0000_0000;
         err_q <= 1'b0;
         skip_q <= 1'b0;
         flow_q <= 1'b0;
         unit_q <= UNIT_RST;
         ftp_q <= 4'h0;
         pass_q <= 15'h0000;
         sw_q <= '0;
         mute_q <= '0;
         pidx_q <= 3'h0;
         unl_q <= 1'b0;
         upls_q <= 1'b0;
         btn_l <= 5'h00;
         for (int i = 0; i < 128; i++) lvl_q[i] <= LVL_RST;
         for (int i = 0; i < 8; i++) hold_q[i] <= HOLD_RST;
      end else begin
         st_q <= st_d;
         cmd_q <= cmd_d;
         arg0_q <= arg0_d;
         arg1_q <= arg1_d;
         arg2_q <= arg2_d;
         arg3_q <= arg3_d;
         reply0_q <= reply0_d;
         reply1_q <= reply1_d;
         err_q <= err_d;
         skip_q <= skip_d;
         flow_q <= flow_d;
         unit_q <= unit_d;
         ftp_q <= ftp_d;
         pass_q <= pass_d;
         sw_q <= sw_d;
         mute_q <= mute_d;
         pidx_q <= pidx_d;
         unl_q <= unl_d;
         upls_q <= upls_d;
         btn_l <= btn_s;
      end
   end

   logic exe;
   assign exe = st_q == ST_EXEC;

   property p_skip;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      exe && !hit |=> skip_q && !err_q;
   endproperty
   a_skip: assert property (p_skip) else $error("Unaddressed command not skipped");

   property p_eq_node;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      exe && op == OP_EQ && !node_ok |-> !eq_we ##1 err_q || !hit;
   endproperty
   a_eq_node: assert property (p_eq_node) else $error("Bad node accepted");

   property p_eq_query;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      exe && qry |-> !eq_we;
   endproperty
   a_eq_query: assert property (p_eq_query) else $error("Query changed a stage");

   property p_lvl_clamp;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      exe && hit && op == OP_LVL && !qry && lv_ok && lv_req > LVL_MAX
      |=> lvl_q[lv_idx] == LVL_MAX[7:0] && !mute_q[lv_idx];
   endproperty
   a_lvl_clamp: assert property (p_lvl_clamp) else $error("Level not clamped");

   property p_lvl_mute;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      exe && hit && op == OP_LVL && !qry && lv_ok && lv_req < LVL_MIN |=> mute_q[lv_idx];
   endproperty
   a_lvl_mute: assert property (p_lvl_mute) else $error("Low level did not mute");

   property p_gate_ro;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      exe && hit && op == OP_GATE && !qry |=> err_q && $stable(reply0_q);
   endproperty
   a_gate_ro: assert property (p_gate_ro) else $error("Gate status accepted a setting");

   property p_gate_hex;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      exe && hit && op == OP_GATE && qry
      |=> reply0_q[15:8] == hex_ch($past(gate_s[7:4])) && reply0_q[7:0] == hex_ch($past(gate_s[3:0]));
   endproperty
   a_gate_hex: assert property (p_gate_hex) else $error("Gate reply digits wrong");

   property p_flow_toggle;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      exe && hit && op == OP_FLOW && !qry && arg0_q[15:0] == 16'h0002 |=> flow_q != $past(flow_q);
   endproperty
   a_flow_toggle: assert property (p_flow_toggle) else $error("Toggle did not invert");

   property p_flow_pace;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      flow_q && !$past(dsr_in, 2) |-> !tx_allow_out;
   endproperty
   a_flow_pace: assert property (p_flow_pace) else $error("Sent without DSR");

   property p_unlock;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      unlock_pulse_out |-> panel_unlocked_out ##1 !unlock_pulse_out;
   endproperty
   a_unlock: assert property (p_unlock) else $error("Unlock pulse without unlock");

   property p_clear;
      @(posedge ref_clk_in) disable iff (!nrst_in)
      exe && hit && op == OP_PASS && clr |=> pass_q == 15'h0000;
   endproperty
   a_clear: assert property (p_clear) else $error("Passcode not cleared");
endmodule // adsc_top

// ---- adsc_host_model.sv ----
// Purpose: Host side of the serial handshake lines
// Assumes: Host answers one cycle after each clock edge
// Notes: A stall drops both the host's DSR and its receive-ready together
module adsc_host_model (
   input wire logic ref_clk_in,
   input wire logic stall_in,
   input wire logic dtr_in,
   output logic dsr_out,
   output logic rx_ready_out,
   output logic sent_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      dsr_out = 1'b1;
      rx_ready_out = 1'b1;
      sent_out = 1'b0;
   end
   always @(posedge ref_clk_in) begin
      dsr_out <= !stall_in;
      rx_ready_out <= !stall_in;
      // Host sends only while the device raises DTR
      sent_out <= dtr_in;
   end
endmodule // adsc_host_model

// ---- tb.sv ----
// Purpose: Self-checking bench for the command interpreter
// Assumes: APB zero wait states, results one edge after the command write
// Notes: Reads queue their expectations; a monitor compares them at the access edge
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import adsc_pkg::*;
   typedef struct {logic [32:0] e; logic [32:0] m;} adsc_note_s;
   adsc_note_s notes[$];
   logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, stall = 0;
   logic [7:0] paddr = 0, gate = 0;
   logic [4:0] btn = 0;
   logic [31:0] pwdata = 0, prdata, rnd = 32'h0000_2618;
   logic pready, pslverr, dtr, txa, unl, pulse, dsr, rxr;
   int err_count = 0, compares = 0, pulses = 0;
   int lv_arg[6] = '{12, 0, 50, -70, 10, -3};
   logic lv_abs[6] = '{1, 1, 1, 1, 1, 0};
   logic [8:0] lv_exp[6], lv_msk[6];
   adsc_top u_dut (.ref_clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .gate_in(gate), .btn_in(btn),
      .dsr_in(dsr), .rx_ready_in(rxr), .dtr_out(dtr), .tx_allow_out(txa),
      .panel_unlocked_out(unl), .unlock_pulse_out(pulse));
   adsc_host_model u_host (.ref_clk_in(clk), .stall_in(stall), .dtr_in(dtr),
      .dsr_out(dsr), .rx_ready_out(rxr), .sent_out());
   initial begin
      forever #2 clk = ~clk;
   end
   function automatic logic [31:0] xs(logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction
   function automatic logic [7:0] hx(logic [3:0] v);
      return (v < 10) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
   endfunction
   function automatic logic [31:0] cw(logic [3:0] op, logic [3:0] ch, logic [2:0] g,
         logic q, logic ab);
      return 32'(op) | (32'(q) << C_QRY) | (32'(ch) << C_CH) | (32'(g) << C_GRP)
         | (32'(ab) << C_ABS);
   endfunction
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pen <= 0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 0;
      pen <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      notes.push_back('{e & m, m});
      apb(0, a, 0);
   endtask
   task automatic run(input logic [31:0] c, input logic [31:0] a0, input logic [1:0] st);
      apb(1, A_ARG0, a0);
      apb(1, A_CMD, c);
      rd(A_STATUS, 33'(st), 33'h3);
   endtask
   always @(posedge clk) begin
      if (psel && pen && pready === 1'b1 && !pwr && notes.size() > 0) begin
         chk({pslverr, prdata} & notes[0].m, notes[0].e);
         void'(notes.pop_front());
      end
   end
   always @(posedge clk) begin
      if (pulse === 1'b1) pulses++;
   end
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #100us;
      err_count++;
      close_out();
   end
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1;
      rd(A_UNIT, 33'h0, 33'h7);
      rnd = xs(rnd);
      lv_arg[1] = int'(rnd % 86) - 65;
      lv_exp = '{9'h00C, 9'(lv_arg[1]) & 9'h0FF, 9'h014, 9'h100, 9'h00A, 9'h007};
      lv_msk = '{9'h1FF, 9'h1FF, 9'h1FF, 9'h100, 9'h1FF, 9'h1FF};
      for (int i = 0; i < 6; i++) begin
         run(cw(OP_LVL, 4, GRP_O, 0, lv_abs[i]), 32'(lv_arg[i]), 0);
         run(cw(OP_LVL, 4, GRP_O, 1, 0), 0, 0);
         rd(A_REPLY0, 33'(lv_exp[i]), 33'(lv_msk[i]));
      end
      run(cw(OP_LVL, 4, GRP_O, 0, 1), 100, 1);
      run(cw(OP_LVL, 4, GRP_O, 0, 1) | 32'h0000_0030, 5, 2);
      run(cw(OP_LVL, 4, GRP_O, 1, 0), 0, 0);
      rd(A_REPLY0, 33'h007, 33'h1FF);
      run(cw(OP_LVL, 4, GRP_O, 0, 1) | 32'h0000_00B0, 5, 0);
      run(cw(OP_LVL, 4, GRP_O, 1, 0), 0, 0);
      rd(A_REPLY0, 33'h005, 33'h1FF);
      $display("level test done");
      run(cw(OP_HOLD, 1, GRP_M, 1, 0), 0, 0);
      rd(A_REPLY0, 33'(HOLD_RST), 33'hFFFF);
      run(cw(OP_HOLD, 1, GRP_M, 0, 0), 32'(HOLD_MIN), 0);
      run(cw(OP_HOLD, 1, GRP_M, 0, 0), 32'(HOLD_MAX) + 1, 1);
      run(cw(OP_HOLD, 1, GRP_M, 1, 0), 0, 0);
      rd(A_REPLY0, 33'(HOLD_MIN), 33'hFFFF);
      $display("hold test done");
      apb(1, A_ARG1, 200);
      run(cw(OP_EQ, 1, GRP_M, 0, 0) | (32'h5 << C_NODE), 2, 1);
      run(cw(OP_EQ, 1, GRP_M, 0, 0) | (32'h3 << C_NODE), 2, 0);
      run(cw(OP_EQ, 1, GRP_M, 1, 0) | (32'h3 << C_NODE), 0, 0);
      rd(A_REPLY0, 33'h6410, 33'h7F_FFF8);
      run(cw(OP_SW, 2, GRP_M, 0, 0) | (32'h1 << C_NALL), 1, 0);
      run(cw(OP_SW, 2, GRP_M, 1, 0) | (32'h4 << C_NODE), 0, 0);
      rd(A_REPLY0, 33'h1, 33'h1);
      run(cw(OP_SW, 2, GRP_O, 0, 0) | (32'h1 << C_NODE), 1, 1);
      run(cw(OP_FTP, 4'hA, 0, 0, 0), 1, 0);
      run(cw(OP_FTP, 1, 0, 1, 0), 0, 0);
      rd(A_REPLY0, 33'h1, 33'h1);
      $display("stage test done");
      rnd = xs(rnd);
      gate <= rnd[7:0];
      repeat (4) @(posedge clk);
      rd(A_GATE, 33'(rnd[7:0]), 33'hFF);
      run(cw(OP_GATE, 0, 0, 1, 0), 0, 0);
      rd(A_REPLY0, {17'h0, hx(rnd[7:4]), hx(rnd[3:0])}, 33'hFFFF);
      run(cw(OP_GATE, 0, 0, 0, 0), 0, 1);
      $display("gate test done");
      run(cw(OP_PASS, 0, 0, 0, 0), 32'h0000_14E6, 1);
      run(cw(OP_PASS, 0, 0, 0, 0), 32'h0000_14E5, 0);
      run(cw(OP_PASS, 0, 0, 1, 0), 0, 0);
      rd(A_REPLY0, 33'h14E5, 33'h7FFF);
      rd(A_STATUS, 33'h0, 33'h8);
      for (int k = -1; k < 5; k++) begin
         btn <= (k < 0) ? 5'h08 : 5'(1 << k);
         repeat (3) @(posedge clk);
         btn <= 5'h00;
         repeat (3) @(posedge clk);
      end
      chk({32'h0, unl}, 33'h1);
      chk(33'(pulses), 33'h1);
      run(cw(OP_PASS, 0, 0, 0, 0) | (32'h1 << C_CLR), 0, 0);
      run(cw(OP_PASS, 0, 0, 1, 0), 0, 0);
      rd(A_REPLY0, 33'h0, 33'h7FFF);
      $display("passcode test done");
      run(cw(OP_FLOW, 0, 0, 0, 0), 1, 0);
      stall <= 1;
      repeat (4) @(posedge clk);
      chk({31'h0, dtr, txa}, 33'h0);
      run(cw(OP_FLOW, 0, 0, 0, 0), 2, 0);
      chk({31'h0, dtr, txa}, 33'h3);
      stall <= 0;
      rd(8'h28, {1'b1, 32'h0}, {1'b1, 32'h0});
      $display("flow and map test done");
      repeat (3) @(posedge clk);
      close_out();
   end
endmodule // tb
